// >>> hdl/pllrc_core.sv
// Synthesiser control core: reconfiguration port, reference mux, reset, power down
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - Seven-bit address picks one 16-bit cell, accessed on the next clock.
// - Write data goes to a shadow register and is committed later.
// - Ready tells the controller another write may be issued.
// - Ready is the completion answer to every strobe taken while idle; a strobe during commit gets none.
// - Write select high writes the cell, low reads it.
// - Nothing happens on the port without the strobe.
// - Each of six outputs is the oscillator divided by 1 to 128.
// - Lock is reached after power-on with no extra reset.
// - Lock drops when the reference stops or its phase shifts.
// - Select high takes primary reference, low takes secondary.
// - Reset acts asynchronously; release resumes synchronously.
// - Power-down stops the synthesiser entirely.
// - Strobe with write select low reads the addressed cell onto read data.
// - Port signals are sampled on the rising clock edge.
// - All control and status signals are active high except arst_n, which is active low.
module pllrc_core
    import pllrc_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [pllrc_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [pllrc_pkg::CFG_ADDR_W-1:0] cfg_addr,
    input wire logic [pllrc_pkg::CFG_DATA_W-1:0] cfg_wdata,
    input wire logic cfg_write_sel,
    input wire logic cfg_strobe,
    output logic [pllrc_pkg::CFG_DATA_W-1:0] cfg_rdata,
    output logic cfg_ack,
    input wire logic ref_clk_primary,
    input wire logic ref_clk_secondary,
    input wire logic ref_clk_select,
    input wire logic synth_rst,
    input wire logic power_down_req,
    output logic [pllrc_pkg::NUM_OUT-1:0] synth_out_clk,
    output logic fb_clk_out,
    output logic fb_clk_out_inv,
    output logic locked
);
    import pllrc_pkg::*;

    pllrc_synth_if synth_bus ();

    // Configuration cells and port sequencer
    logic [CFG_DATA_W-1:0] cells_q [CFG_DEPTH];
    pllrc_cfg_state_e state_q;
    pllrc_cfg_state_e state_d;
    logic [CFG_ADDR_W-1:0] shadow_addr_q;
    logic [CFG_DATA_W-1:0] shadow_data_q;
    logic [CFG_DATA_W-1:0] rdata_q;
    logic cfg_ack_q;
    logic take;
    logic take_wr;
    logic take_rd;

    // Synthesiser run control
    logic hold_rst;
    logic run_meta_q;
    logic run_q;
    logic ref_sel;
    logic vco_q;
    logic fb_q;
    logic fb_inv_q;

    // Wishbone slave
    logic [1:0] ctrl_q;
    logic [31:0] wb_dat_q;
    logic wb_ack_q;
    logic wb_hit;
    logic wb_commit;
    logic [31:0] status_word;

    // A strobe is taken only while idle; a strobe during commit is ignored
    assign take = cfg_strobe && (state_q == CFG_IDLE);
    assign take_wr = take && cfg_write_sel;
    assign take_rd = take && !cfg_write_sel;

    // Sequencer next state: a write spends one cycle committing the shadow
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            CFG_IDLE:
            begin
                if (take_wr)
                    state_d = CFG_COMMIT;
            end
            CFG_COMMIT:
                state_d = CFG_IDLE;
            default:
                state_d = CFG_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            state_q <= CFG_IDLE;
        else
            state_q <= state_d;
    end

    // Shadow register catches write data and address at the strobe
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shadow_addr_q <= 7'h00;
            shadow_data_q <= CFG_CELL_RST;
        end
        else if (take_wr)
        begin
            shadow_addr_q <= cfg_addr;
            shadow_data_q <= cfg_wdata;
        end
    end

    // Cells change only in the commit cycle, so dividers never see half a write
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int k = 0; k < CFG_DEPTH; k++)
                cells_q[k] <= CFG_CELL_RST;
        end
        else if (state_q == CFG_COMMIT)
            cells_q[shadow_addr_q] <= shadow_data_q;
    end

    // Read data is loaded on a read and held through later writes
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rdata_q <= CFG_CELL_RST;
        else if (take_rd)
            rdata_q <= cells_q[cfg_addr];
    end

    // Ready: one-cycle pulse after a read, or after the commit of a write
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            cfg_ack_q <= 1'b0;
        else
            cfg_ack_q <= take_rd || (state_q == CFG_COMMIT);
    end

    assign cfg_rdata = rdata_q;
    assign cfg_ack = cfg_ack_q;

    // Any reset source or power-down stops the synthesiser at once
    assign hold_rst = synth_rst || power_down_req || ctrl_q[CTRL_SOFT_RST_BIT]
                      || ctrl_q[CTRL_SOFT_PWRDN_BIT] || !arst_n;

    // Asynchronous stop, release through two flops so restart is clean
    always_ff @(posedge clock or posedge hold_rst)
    begin
        if (hold_rst)
            run_meta_q <= 1'b0;
        else
            run_meta_q <= 1'b1;
    end

    always_ff @(posedge clock or posedge hold_rst)
    begin
        if (hold_rst)
            run_q <= 1'b0;
        else
            run_q <= run_meta_q;
    end

    // Reference input multiplexer
    assign ref_sel = ref_clk_select ? ref_clk_primary : ref_clk_secondary;

    // Oscillator model follows the chosen reference at unity ratio
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            vco_q <= 1'b0;
        else
            vco_q <= run_q && ref_sel;
    end

    assign synth_bus.run = run_q;
    assign synth_bus.vco_level = vco_q;
    // Reference must be slower than half the system clock to be seen at all
    assign synth_bus.vco_edge = run_q && ref_sel && !vco_q;

    // Feedback outputs; quiet while stopped, inverted copy is output only
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fb_q <= 1'b0;
            fb_inv_q <= 1'b0;
        end
        else
        begin
            fb_q <= run_q && vco_q;
            fb_inv_q <= run_q && !vco_q;
        end
    end

    assign fb_clk_out = fb_q;
    assign fb_clk_out_inv = fb_inv_q;

    // Lock detection
    pllrc_lock_mon u_lock_mon (
        .clock(clock),
        .arst_n(arst_n),
        .synth(synth_bus)
    );

    assign locked = synth_bus.lock;

    // One divider per output, steered by its configuration cell
    for (genvar i = 0; i < NUM_OUT; i++)
    begin : g_out
        pllrc_divider u_div (
            .clock(clock),
            .arst_n(arst_n),
            .synth(synth_bus),
            .div_sel(cells_q[int'(DIV_BASE_ADDR) + i][DIV_W-1:0]),
            .out_clk(synth_out_clk[i])
        );
    end

    // Wishbone: request seen once, ack one cycle later, then dropped
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_q;
    assign wb_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_q;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            wb_ack_q <= 1'b0;
        else
            wb_ack_q <= wb_hit;
    end

    // Status word shows the block's live state
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[STAT_LOCK_BIT] = synth_bus.lock;
        status_word[STAT_STOP_BIT] = synth_bus.ref_stopped;
        status_word[STAT_BUSY_BIT] = (state_q != CFG_IDLE);
        status_word[STAT_RUN_BIT] = run_q;
    end

    // Read data captured at the request; unmapped offsets read as zero
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            wb_dat_q <= 32'h0000_0000;
        else if (wb_hit && !wb_we_i)
        begin
            if (wb_adr_i == WB_CTRL_OFF)
                wb_dat_q <= {30'h0000_0000, ctrl_q};
            else if (wb_adr_i == WB_STATUS_OFF)
                wb_dat_q <= status_word;
            else
                wb_dat_q <= 32'h0000_0000;
        end
    end

    // Control write lands on the acknowledging edge, byte lane 0 only
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            ctrl_q <= CTRL_RST_VAL;
        else if (wb_commit && wb_sel_i[0] && (wb_adr_i == WB_CTRL_OFF))
            ctrl_q <= wb_dat_i[1:0];
    end

    assign wb_dat_o = wb_dat_q;
    assign wb_ack_o = wb_ack_q;
endmodule

// >>> common/pllrc_pkg.sv
// Shared constants and types for the synthesiser control block
package pllrc_pkg;
    // Reconfiguration port geometry
    localparam int CFG_ADDR_W = 7;
    localparam int CFG_DATA_W = 16;
    localparam int CFG_DEPTH = 128;
    localparam logic [15:0] CFG_CELL_RST = 16'h0000;

    // Output dividers: cell at DIV_BASE_ADDR + n holds divide-1 of output n
    localparam int NUM_OUT = 6;
    localparam int DIV_W = 7;
    localparam logic [6:0] DIV_BASE_ADDR = 7'h08;
    localparam logic [6:0] DIV_BYPASS = 7'h00;

    // Timing: reference stop timeout, a longest time, so rounded down
    localparam int CLK_PERIOD_NS = 10;
    localparam int REF_STOP_NS = 2000;
    localparam int PERIOD_W = 8;
    localparam logic [7:0] STOP_CYCLES = 8'(REF_STOP_NS / CLK_PERIOD_NS);
    localparam logic [3:0] LOCK_EDGES = 4'h8;

    // Wishbone slave map
    localparam int WB_ADR_W = 4;
    localparam logic [3:0] WB_CTRL_OFF = 4'h0;
    localparam logic [3:0] WB_STATUS_OFF = 4'h4;
    localparam int CTRL_SOFT_RST_BIT = 0;
    localparam int CTRL_SOFT_PWRDN_BIT = 1;
    localparam logic [1:0] CTRL_RST_VAL = 2'h0;
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_STOP_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_RUN_BIT = 3;

    // Reconfiguration port sequencer
    typedef enum logic {CFG_IDLE, CFG_COMMIT} pllrc_cfg_state_e;
endpackage

// >>> common/pllrc_synth_if.sv
// Internal oscillator model signals shared by core, lock monitor and dividers
`timescale 1ns/10ps
interface pllrc_synth_if;
    logic run;
    logic vco_edge;
    logic vco_level;
    logic lock;
    logic ref_stopped;

    modport core (output run, output vco_edge, output vco_level,
                  input lock, input ref_stopped);
    modport mon (input run, input vco_edge, output lock, output ref_stopped);
    modport div (input run, input vco_edge, input vco_level);
endinterface

// >>> hdl/pllrc_lock_mon.sv
// Lock monitor: watches the oscillator period and flags lock or stopped reference
`timescale 1ns/10ps
module pllrc_lock_mon
    import pllrc_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    pllrc_synth_if.mon synth
);
    import pllrc_pkg::*;

    logic [PERIOD_W-1:0] period_q;
    logic [PERIOD_W-1:0] last_q;
    logic [3:0] match_q;
    logic lock_q;
    logic stop_q;
    logic close;

    // One cycle of slack absorbs sampling jitter of the reference
    assign close = (period_q == last_q) || (period_q == last_q + 8'h01)
                   || (last_q == period_q + 8'h01);

    // Period tracking; lock only after a run of matching periods
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            period_q <= 8'h00;
            last_q <= 8'h00;
            match_q <= 4'h0;
            lock_q <= 1'b0;
            stop_q <= 1'b0;
        end
        else if (!synth.run)
        begin
            period_q <= 8'h00;
            last_q <= 8'h00;
            match_q <= 4'h0;
            lock_q <= 1'b0;
            stop_q <= 1'b0;
        end
        else if (synth.vco_edge)
        begin
            period_q <= 8'h00;
            last_q <= period_q;
            stop_q <= 1'b0;
            if (close)
            begin
                if (match_q != LOCK_EDGES)
                    match_q <= match_q + 4'h1;
                lock_q <= (match_q >= LOCK_EDGES - 4'h1);
            end
            else
            begin
                match_q <= 4'h0;
                lock_q <= 1'b0;
            end
        end
        else if (period_q == STOP_CYCLES)
        begin
            stop_q <= 1'b1;
            match_q <= 4'h0;
            lock_q <= 1'b0;
        end
        else
            period_q <= period_q + 8'h01;
    end

    assign synth.lock = lock_q;
    assign synth.ref_stopped = stop_q;
endmodule

// >>> hdl/pllrc_divider.sv
// Output divider: oscillator divided by 1 (bypass) to 128
`timescale 1ns/10ps
module pllrc_divider
    import pllrc_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    pllrc_synth_if.div synth,
    input wire logic [pllrc_pkg::DIV_W-1:0] div_sel,
    output logic out_clk
);
    import pllrc_pkg::*;

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_nxt;
    logic [DIV_W:0] half;
    logic out_q;

    // High for the first ceil(N/2) oscillator periods of N = div_sel + 1
    assign half = 8'(({1'b0, div_sel} + 8'h02) >> 1);
    assign cnt_nxt = (cnt_q >= div_sel) ? DIV_BYPASS : cnt_q + 7'h01;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= DIV_BYPASS;
            out_q <= 1'b0;
        end
        else if (!synth.run)
        begin
            cnt_q <= DIV_BYPASS;
            out_q <= 1'b0;
        end
        else if (div_sel == DIV_BYPASS)
        begin
            cnt_q <= DIV_BYPASS;
            out_q <= synth.vco_level;
        end
        else if (synth.vco_edge)
        begin
            cnt_q <= cnt_nxt;
            out_q <= {1'b0, cnt_nxt} < half;
        end
    end

    assign out_clk = out_q;
endmodule

// >>> verification/pllrc_core_asserts.sv
// Port checker for the synthesiser control core
`timescale 1ns/10ps
module pllrc_core_asserts
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic cfg_write_sel,
    input wire logic cfg_strobe,
    input wire logic [15:0] cfg_rdata,
    input wire logic cfg_ack,
    input wire logic ref_clk_primary,
    input wire logic ref_clk_secondary,
    input wire logic ref_clk_select,
    input wire logic synth_rst,
    input wire logic power_down_req,
    input wire logic fb_clk_out,
    input wire logic fb_clk_out_inv,
    input wire logic locked
);
    logic commit_q;
    logic ref_q;
    logic [8:0] quiet_q;
    logic sel_ref;
    logic rd_go;
    logic wr_go;
    // A strobe in the commit cycle is refused, so it must not count as taken
    assign sel_ref = ref_clk_select ? ref_clk_primary : ref_clk_secondary;
    assign rd_go = cfg_strobe && !cfg_write_sel && !commit_q;
    assign wr_go = cfg_strobe && cfg_write_sel && !commit_q;
    // Commit cycle tracker
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            commit_q <= 1'b0;
        else
            commit_q <= wr_go;
    end
    // Cycles since the selected reference last rose, saturating
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_q <= 1'b0;
            quiet_q <= 9'h000;
        end
        else
        begin
            ref_q <= sel_ref;
            if (sel_ref && !ref_q)
                quiet_q <= 9'h000;
            else if (quiet_q != 9'h1ff)
                quiet_q <= quiet_q + 9'h001;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_read_ack_next: assert property (rd_go |=> cfg_ack)
        else $error("read not answered next cycle");
    a_write_ack_late: assert property (wr_go |=> !cfg_ack ##1 cfg_ack)
        else $error("write not answered in second cycle");
    a_ack_has_cause: assert property (cfg_ack |-> $past(rd_go) || $past(wr_go, 2))
        else $error("ready without a taken strobe");
    a_rdata_held: assert property (!$past(rd_go) |-> $stable(cfg_rdata))
        else $error("read data changed without a read");
    a_bus_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");
    a_stop_unlock: assert property (quiet_q >= 9'h0d7 |-> !locked)
        else $error("lock held with reference stopped");
    a_pwrdn_off: assert property (power_down_req [*2] |-> !locked && !fb_clk_out && !fb_clk_out_inv)
        else $error("outputs alive in power down");
    a_reset_off: assert property (synth_rst [*2] |-> !locked && !fb_clk_out && !fb_clk_out_inv)
        else $error("outputs alive in reset");
    a_release_sync: assert property ($fell(synth_rst) |-> !locked)
        else $error("lock present at reset release");
    a_fb_inverse: assert property (locked |-> fb_clk_out != fb_clk_out_inv)
        else $error("inverted feedback not the complement while locked");
endmodule
bind pllrc_core pllrc_core_asserts pllrc_core_asserts_i (.clock, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .cfg_write_sel, .cfg_strobe, .cfg_rdata, .cfg_ack, .ref_clk_primary,
    .ref_clk_secondary, .ref_clk_select, .synth_rst, .power_down_req, .fb_clk_out,
    .fb_clk_out_inv, .locked);

// >>> verification/pllrc_fabric_ctl.sv
// Fabric-side controller model driving the reconfiguration port
`timescale 1ns/10ps
module pllrc_fabric_ctl
(
    input wire logic clock,
    input wire logic cfg_ack,
    output logic [pllrc_pkg::CFG_ADDR_W-1:0] cfg_addr,
    output logic [pllrc_pkg::CFG_DATA_W-1:0] cfg_wdata,
    output logic cfg_write_sel,
    output logic cfg_strobe
);
    import pllrc_pkg::*;
    // Quiet port until the first transaction
    initial
    begin
        cfg_addr = 7'h00;
        cfg_wdata = 16'h0000;
        cfg_write_sel = 1'b0;
        cfg_strobe = 1'b0;
    end
    // One transaction; idle lines are scrambled so stale values cannot pass
    task automatic xfer(input logic we, input logic [6:0] a, input logic [15:0] d, input int gap);
        int n;
        if (gap > 0)
        begin
            cfg_addr <= ~cfg_addr;
            cfg_wdata <= ~cfg_wdata;
            repeat (gap) @(posedge clock);
        end
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_write_sel <= we;
        cfg_strobe <= 1'b1;
        @(posedge clock);
        cfg_strobe <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (cfg_ack !== 1'b1 && n < 20);
    endtask
endmodule

// >>> verification/test_pllrc_core.sv
// Self-checking testbench for the synthesiser control core
`timescale 1ns/10ps
module test_pllrc_core;
    import pllrc_pkg::*;
    logic clock, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [6:0] cfg_addr;
    logic [15:0] cfg_wdata, cfg_rdata, last_rd;
    logic cfg_write_sel, cfg_strobe, cfg_ack, locked, fb_clk_out, fb_clk_out_inv;
    logic ref_clk_primary, ref_clk_secondary, ref_clk_select, synth_rst, power_down_req;
    logic run_p, run_s;
    logic [5:0] synth_out_clk;
    logic [15:0] cells [128];
    logic [15:0] cfg_q [$];
    logic [31:0] wb_q [$];
    logic [31:0] wb_m [$];
    int n_fail, n_compared, cyc, per, v;
    pllrc_core pllrc_core_i (.*);
    pllrc_fabric_ctl pllrc_fabric_ctl_i (.*);
    // 100 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // References of 8 and 12 cycles, each stoppable; also the run timeout
    // Both are plain sources, never a cascaded block's output
    always @(posedge clock)
    begin
        if (run_p && cyc % 4 == 0) ref_clk_primary <= ~ref_clk_primary;
        if (run_s && cyc % 6 == 0) ref_clk_secondary <= ~ref_clk_secondary;
        cyc <= cyc + 1;
        if (cyc == 40000) summarize(1);
    end
    // Each answer retires the oldest expectation
    always @(posedge clock)
    begin
        if (cfg_ack === 1'b1 && cfg_q.size() > 0)
            cmp_word({16'h0000, cfg_rdata}, {16'h0000, cfg_q.pop_front()}, 32'hffffffff);
        if (wb_ack_o === 1'b1 && wb_q.size() > 0)
            cmp_word(wb_dat_o, wb_q.pop_front(), wb_m.pop_front());
    end
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        n_compared++;
        if ((got & m) !== (exp & m))
        begin
            n_fail++;
            $display("ERROR %0t data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t lock %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmp_per(input int got, input int exp);
        n_compared++;
        if (got != exp)
        begin
            n_fail++;
            $display("ERROR %0t period %0d expected %0d", $time, got, exp);
        end
    endtask
    // Port transaction with its expected read data noted first
    task automatic cfg_op(input logic we, input logic [6:0] a, input logic [15:0] d, input int gap);
        if (we)
            cells[a] = d;
        else
            last_rd = cells[a];
        cfg_q.push_back(last_rd);
        pllrc_fabric_ctl_i.xfer(we, a, d, gap);
    endtask
    // Classic single bus cycle, held until acknowledge, then one idle cycle
    task automatic wb_op(input logic we, input logic [3:0] a, input logic [3:0] s,
                         input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
        int n;
        wb_q.push_back(e);
        wb_m.push_back(m);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wait_lock(input logic e, input int lim);
        int n;
        n = 0;
        while (locked !== e && n < lim)
        begin
            @(posedge clock);
            n++;
        end
        cmp_bit(locked, e);
    endtask
    // Cycles spanning two periods, after one settling period
    task automatic measure(input int k, output int p);
        int n, r;
        logic pv;
        n = 0;
        r = 0;
        p = 0;
        pv = synth_out_clk[k];
        while (r < 4 && n < 5000)
        begin
            @(posedge clock);
            n++;
            if (r == 2 || r == 3) p++;
            if (synth_out_clk[k] && !pv) r++;
            pv = synth_out_clk[k];
        end
    endtask
    task automatic summarize(input int extra);
        n_fail += extra + cfg_q.size() + wb_q.size();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(95));
        {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, synth_rst, power_down_req} = 6'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
        {ref_clk_primary, ref_clk_secondary, ref_clk_select, run_p, run_s} = 5'h07;
        {n_fail, n_compared, cyc, last_rd} = '0;
        foreach (cells[i]) cells[i] = 16'h0000;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        wait_lock(1'b1, 400);
        cfg_op(1'b1, 7'h7f, 16'ha5c3, 0);
        cfg_op(0, 7'h7f, 16'h0000, 0);
        cfg_op(0, 7'h00, 16'h0000, 0);
        repeat (24) cfg_op(1'($urandom), 7'($urandom), 16'($urandom), $urandom % 3);
        for (int k = 0; k < NUM_OUT; k++)
        begin
            v = (k == 5) ? 127 : k;
            cfg_op(1'b1, DIV_BASE_ADDR + 7'(k), 16'(v), 1);
            measure(k, per);
            cmp_per(per, 16 * (v + 1));
        end
        wb_op(1'b1, WB_CTRL_OFF, 4'hf, 32'h2, 32'h0, 32'h0);
        wb_op(1'b1, WB_CTRL_OFF, 4'he, 32'h0, 32'h0, 32'h0);
        wb_op(1'b0, WB_CTRL_OFF, 4'hf, 32'h0, 32'h2, 32'h3);
        wb_op(1'b0, WB_STATUS_OFF, 4'hf, 32'h0, 32'h0, 32'h9);
        wb_op(1'b1, 4'h8, 4'hf, 32'hffffffff, 32'h0, 32'h0);
        wb_op(1'b0, 4'h8, 4'hf, 32'h0, 32'h0, 32'hffffffff);
        wb_op(1'b1, WB_CTRL_OFF, 4'hf, 32'h0, 32'h0, 32'h0);
        wait_lock(1'b1, 400);
        power_down_req <= 1'b1;
        repeat (10) @(posedge clock);
        cmp_bit(locked, 1'b0);
        power_down_req <= 1'b0;
        wait_lock(1'b1, 400);
        run_p <= 1'b0;
        wait_lock(1'b0, 260);
        wb_op(1'b0, WB_STATUS_OFF, 4'hf, 32'h0, 32'ha, 32'hb);
        synth_rst <= 1'b1;
        run_p <= 1'b1;
        @(posedge clock);
        ref_clk_select <= 1'b0;
        repeat (3) @(posedge clock);
        synth_rst <= 1'b0;
        wait_lock(1'b1, 400);
        run_s <= 1'b0;
        wait_lock(1'b0, 260);
        synth_rst <= 1'b1;
        run_s <= 1'b1;
        @(posedge clock);
        ref_clk_select <= 1'b1;
        repeat (3) @(posedge clock);
        synth_rst <= 1'b0;
        wait_lock(1'b1, 400);
        cfg_op(0, 7'h7f, 16'h0000, 2);
        repeat (4) @(posedge clock);
        summarize(0);
    end
endmodule
